/* fcpd_pkg.sv */
// Package of constants and types for the floppy command parameter decoder
// ---------------------------------------------
// Operation
// ---------------------------------------------
// Operation
// - With implied seek enabled, seek to command cylinder before cylinder-bearing read/write
// - Final sector number marks the last sector of the track in multi-sector runs
// - Gap parameter alters second gap length only in perpendicular mode
// - Inter-sector gap length sets gap between sectors, sync field excluded
// - Head select picks side 0 or 1, matched against sector ID head
// - After head load, wait the head-load interval before read or write
// - Unload head once head-unload interval elapses after execution ends
// - Lock decides whether software reset restores FIFO enable, threshold, precomp track
// - Density one selects MFM, zero selects FM
// - Multi-track runs head 0 sectors then continues at first sector of head 1
// - Sector size is 128 times two to the size code, codes up to 07
// - Size code 00 gives 128-byte sectors, transfer length from special sector length
// - FIFO enable is active low, disabled by default
// - Short special length: reads drop the remainder, writes pad zeros, CRC covers all
package fcpd_pkg;

	// ---------------------------------------------
	// Bus map
	// ---------------------------------------------
	localparam logic [7:0]  ADDR_CONFIG  = 8'h00;
	localparam logic [7:0]  ADDR_COMMAND = 8'h04;
	localparam logic [7:0]  ADDR_TRACK   = 8'h08;
	localparam logic [7:0]  ADDR_TIMING  = 8'h0C;
	localparam logic [7:0]  ADDR_CONTROL = 8'h10;
	localparam logic [7:0]  ADDR_STATUS  = 8'h14;
	localparam logic [7:0]  ADDR_SECTOR  = 8'h18;

	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int CFG_FIFO_EN_N  = 0;
	localparam int CFG_THR_LSB    = 8;
	localparam int CFG_PRE_LSB    = 16;
	localparam int CFG_LOCK       = 24;
	localparam int CFG_SEEK_EN    = 25;
	localparam int CFG_PERP       = 26;
	localparam int CMD_START      = 31;
	localparam int CMD_WRITE      = 30;
	localparam int CMD_MT         = 29;
	localparam int CMD_MFM        = 28;
	localparam int CMD_HEAD       = 27;
	localparam int CTL_SW_RESET   = 0;
	localparam int CTL_SEC_DONE   = 1;
	localparam int CTL_SEEK_DONE  = 2;

	// ---------------------------------------------
	// Reset values and timing
	// ---------------------------------------------
	localparam logic       FIFO_EN_N_RST = 1'b1;
	localparam logic [3:0] FIFO_THR_RST  = 4'h0;
	localparam logic [7:0] PRECOMP_START_TRACK_RST    = 8'h00;
	localparam logic [7:0] SPEC_LEN_RST  = 8'hFF;
	localparam logic [7:0] GAP_RST       = 8'h1B;
	localparam int         CLK_MHZ       = 250;
	localparam int         TICK_US       = 1;
	localparam int         TICK_CYCLES   = CLK_MHZ * TICK_US;
	localparam logic [2:0] SIZE_CODE_MAX = 3'h7;
	localparam logic [15:0] BASE_SECTOR  = 16'h0080;

	typedef enum {FCPD_IDLE, FCPD_SEEK, FCPD_LOAD, FCPD_XFER, FCPD_HOLD} fcpd_state_t;

	typedef struct packed {
		logic       fifo_enable_n;
		logic [3:0] fifo_threshold;
		logic [7:0] precomp_start_track;
	} fcpd_lockable_t;

	typedef struct packed {
		logic       write_op;
		logic       multi_track_flag;
		logic       mfm;
		logic       head_select;
		logic [7:0] cylinder;
		logic [7:0] first_sector;
		logic [7:0] final_sector_number;
		logic [2:0] size_code;
		logic [7:0] special_sector_length;
	} fcpd_cmd_t;

endpackage : fcpd_pkg

/* fcpd_delay.sv */
// Interval down-counter driven by a tick enable
`timescale 1ns/10ps
module fcpd_delay
	import fcpd_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] count;
		logic         busy;
	} fcpd_dly_t;

	fcpd_dly_t st_reg;
	fcpd_dly_t st_next;

	always_comb begin
		st_next = st_reg;
		done    = st_reg.busy && st_reg.count == '0;
		if (load) begin
			st_next.count = value;
			st_next.busy  = 1'b1;
		end else if (done) begin
			st_next.busy = 1'b0;
		end else if (st_reg.busy && tick) begin
			st_next.count = st_reg.count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule : fcpd_delay

/* fcpd_top.sv */
// AHB-Lite slave sequencing floppy command parameters for one transfer
`timescale 1ns/10ps
module fcpd_top
	import fcpd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             head_load,
	output logic             head_select,
	output logic             seek_req,
	output logic      [7:0]  seek_cylinder,
	output logic             mfm_mode,
	output logic             xfer_active,
	output logic             write_active,
	output logic      [7:0]  cur_sector,
	output logic      [15:0] sector_bytes,
	output logic      [15:0] host_bytes,
	output logic      [7:0]  gap3_len,
	output logic      [7:0]  gap2_len,
	output logic             fifo_enable_n,
	output logic      [3:0]  fifo_threshold,
	output logic      [7:0]  precomp_start_track
);
	// ---------------------------------------------
	// Reset release
	// ---------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	typedef struct packed {
		fcpd_state_t    state;
		fcpd_lockable_t lockable;
		logic           lock;
		logic           seek_en;
		logic           perp;
		fcpd_cmd_t      cmd;
		logic [7:0]     head_load_delay;
		logic [7:0]     head_unload_delay;
		logic [7:0]     inter_sector_gap_length;
		logic [7:0]     gap;
		logic [7:0]     sector;
		logic           head;
		logic           head_loaded;
		logic [8:0]     tick_cnt;
		logic           ph_valid;
		logic           ph_write;
		logic [7:0]     ph_addr;
		logic [31:0]    rdata;
	} fcpd_regs_t;

	fcpd_regs_t st_reg;
	fcpd_regs_t st_next;

	logic tick;
	logic hlt_load;
	logic hlt_done;
	logic hut_load;
	logic hut_done;

	assign tick = st_reg.tick_cnt == 9'(TICK_CYCLES - 1);

	// Head-load and head-unload intervals counted in microsecond ticks
	fcpd_delay #(.W(8)) u_hlt (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.tick   (tick),
		.load   (hlt_load),
		.value  (st_reg.head_load_delay),
		.done   (hlt_done)
	);

	fcpd_delay #(.W(8)) u_hut (
		.sys_clk(sys_clk),
		.rst_n  (rst_n),
		.tick   (tick),
		.load   (hut_load),
		.value  (st_reg.head_unload_delay),
		.done   (hut_done)
	);

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	logic [31:0] wd;
	logic        addr_ok;
	logic        last_sec;
	logic        sw_rst;

	always_comb begin
		st_next  = st_reg;
		wd       = hwdata;
		hlt_load = 1'b0;
		hut_load = 1'b0;
		st_next.tick_cnt = tick ? 9'h000 : st_reg.tick_cnt + 9'h001;
		last_sec = st_reg.sector == st_reg.cmd.final_sector_number;
		addr_ok  = hsel && htrans[1] && hready;
		sw_rst   = st_reg.ph_valid && st_reg.ph_write && st_reg.ph_addr == ADDR_CONTROL
			&& wd[CTL_SW_RESET];
		st_next.ph_valid = addr_ok;
		if (addr_ok) begin
			st_next.ph_write = hwrite;
			st_next.ph_addr  = haddr[7:0];
		end
		// Registers are read one cycle after the address phase, no wait states
		if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				ADDR_CONFIG: st_next.rdata = {5'h00, st_reg.perp, st_reg.seek_en, st_reg.lock,
					st_reg.lockable.precomp_start_track, 4'h0, st_reg.lockable.fifo_threshold,
					7'h00, st_reg.lockable.fifo_enable_n};
				ADDR_TIMING: st_next.rdata = {st_reg.gap, st_reg.inter_sector_gap_length, st_reg.head_unload_delay, st_reg.head_load_delay};
				ADDR_STATUS: st_next.rdata = {17'h00000, st_reg.head_loaded, st_reg.head,
					3'(st_reg.state), st_reg.sector, 2'b00};
				default:     st_next.rdata = 32'h0000_0000;
			endcase
		end
		if (st_reg.ph_valid && st_reg.ph_write) begin
			case (st_reg.ph_addr)
				ADDR_CONFIG: begin
					st_next.lockable.fifo_enable_n       = wd[CFG_FIFO_EN_N];
					st_next.lockable.fifo_threshold      = wd[CFG_THR_LSB +: 4];
					st_next.lockable.precomp_start_track = wd[CFG_PRE_LSB +: 8];
					st_next.lock    = wd[CFG_LOCK];
					st_next.seek_en = wd[CFG_SEEK_EN];
					st_next.perp    = wd[CFG_PERP];
				end
				ADDR_TIMING: begin
					st_next.head_load_delay = wd[7:0];
					st_next.head_unload_delay = wd[15:8];
					st_next.inter_sector_gap_length = wd[23:16];
					st_next.gap = wd[31:24];
				end
				ADDR_TRACK: begin
					st_next.cmd.cylinder            = wd[7:0];
					st_next.cmd.first_sector        = wd[15:8];
					st_next.cmd.final_sector_number = wd[23:16];
				end
				ADDR_SECTOR: begin
					st_next.cmd.special_sector_length = wd[7:0];
				end
				ADDR_COMMAND: if (wd[CMD_START] && st_reg.state == FCPD_IDLE) begin
					st_next.cmd.write_op         = wd[CMD_WRITE];
					st_next.cmd.multi_track_flag = wd[CMD_MT];
					st_next.cmd.mfm              = wd[CMD_MFM];
					st_next.cmd.head_select      = wd[CMD_HEAD];
					st_next.cmd.size_code        = wd[2:0];
					st_next.sector = st_reg.cmd.first_sector;
					st_next.head   = wd[CMD_HEAD];
					st_next.state  = st_reg.seek_en ? FCPD_SEEK : FCPD_LOAD;
				end
				ADDR_CONTROL: begin
					if (wd[CTL_SW_RESET]) begin
						st_next.state = FCPD_IDLE;
						// Dropping the head makes the next command wait a full load interval
						st_next.head_loaded = 1'b0;
						if (!st_reg.lock) begin
							st_next.lockable = '{FIFO_EN_N_RST, FIFO_THR_RST, PRECOMP_START_TRACK_RST};
						end
					end else if (wd[CTL_SEEK_DONE] && st_reg.state == FCPD_SEEK) begin
						st_next.state = FCPD_LOAD;
					end else if (wd[CTL_SEC_DONE] && st_reg.state == FCPD_XFER) begin
						if (!last_sec) begin
							st_next.sector = st_reg.sector + 8'h01;
						end else if (st_reg.cmd.multi_track_flag && !st_reg.head) begin
							st_next.head   = 1'b1;
							st_next.sector = st_reg.cmd.first_sector;
						end else begin
							st_next.state = FCPD_HOLD;
							hut_load      = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Software reset outranks sequencing, else a finishing load could still enter XFER
		case (sw_rst ? FCPD_IDLE : st_reg.state)
			FCPD_LOAD: begin
				if (!st_reg.head_loaded) begin
					st_next.head_loaded = 1'b1;
					hlt_load = 1'b1;
				end else if (hlt_done || st_reg.head_loaded && !hlt_load && st_reg.head_load_delay == 8'h00) begin
					st_next.state = FCPD_XFER;
				end
			end
			FCPD_HOLD: begin
				if (hut_done) begin
					st_next.head_loaded = 1'b0;
					st_next.state       = FCPD_IDLE;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg          <= '0;
			st_reg.state    <= FCPD_IDLE;
			st_reg.lockable <= '{FIFO_EN_N_RST, FIFO_THR_RST, PRECOMP_START_TRACK_RST};
			st_reg.inter_sector_gap_length      <= GAP_RST;
			st_reg.gap      <= GAP_RST;
			st_reg.cmd.special_sector_length <= SPEC_LEN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign hrdata        = st_reg.rdata;
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign head_load     = st_reg.head_loaded;
	assign head_select   = st_reg.head;
	assign seek_req      = st_reg.state == FCPD_SEEK;
	assign seek_cylinder = st_reg.cmd.cylinder;
	assign mfm_mode      = st_reg.cmd.mfm;
	assign xfer_active   = st_reg.state == FCPD_XFER;
	assign write_active  = xfer_active && st_reg.cmd.write_op;
	assign cur_sector    = st_reg.sector;
	assign sector_bytes  = BASE_SECTOR << st_reg.cmd.size_code;
	// Remainder beyond this is read and dropped, or written as zeros; CRC spans sector_bytes
	assign host_bytes    = (st_reg.cmd.size_code == 3'h0) ?
		((st_reg.cmd.special_sector_length < 8'h80) ?
			{8'h00, st_reg.cmd.special_sector_length} : BASE_SECTOR) : sector_bytes;
	assign gap3_len      = st_reg.inter_sector_gap_length;
	assign gap2_len      = st_reg.perp ? st_reg.gap : GAP_RST;
	assign fifo_enable_n       = st_reg.lockable.fifo_enable_n;
	assign fifo_threshold      = st_reg.lockable.fifo_threshold;
	assign precomp_start_track = st_reg.lockable.precomp_start_track;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	property p_seek_first;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_reg.state == FCPD_IDLE && st_next.state != FCPD_IDLE && st_reg.seek_en) |=> seek_req;
	endproperty
	a_seek_first: assert property (p_seek_first) else $error("No seek before transfer");

	property p_size;
		@(posedge sys_clk) disable iff (!rst_n)
		$onehot(sector_bytes) && sector_bytes >= BASE_SECTOR
			&& (st_reg.cmd.size_code != SIZE_CODE_MAX || sector_bytes == 16'h4000);
	endproperty
	a_size: assert property (p_size) else $error("Sector size wrong");

	property p_fifo_default;
		@(posedge sys_clk) $rose(rst_n) |-> fifo_enable_n;
	endproperty
	a_fifo_default: assert property (p_fifo_default) else $error("FIFO not disabled");

	property p_lock_keep;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_reg.lock && st_reg.ph_valid && st_reg.ph_write && st_reg.ph_addr == ADDR_CONTROL
			&& hwdata[CTL_SW_RESET]) |=> $stable(precomp_start_track);
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("Locked value lost");

	property p_load_wait;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(head_load) && st_reg.head_load_delay > 8'h01 |-> !xfer_active [*8];
	endproperty
	a_load_wait: assert property (p_load_wait) else $error("Transfer before load time");

	property p_gap2;
		@(posedge sys_clk) disable iff (!rst_n)
		!st_reg.perp |-> gap2_len == GAP_RST;
	endproperty
	a_gap2: assert property (p_gap2) else $error("Gap 2 altered outside perpendicular");

	property p_mt_wrap;
		@(posedge sys_clk) disable iff (!rst_n)
		(xfer_active && $rose(head_select)) |->
			st_reg.cmd.multi_track_flag && cur_sector == st_reg.cmd.first_sector;
	endproperty
	a_mt_wrap: assert property (p_mt_wrap) else $error("Head 1 not started at first sector");

	property p_swr_unload;
		@(posedge sys_clk) disable iff (!rst_n)
		sw_rst |=> !head_load && !xfer_active && !seek_req;
	endproperty
	a_swr_unload: assert property (p_swr_unload) else $error("Head still loaded after reset");

endmodule : fcpd_top

/* fcpd_drive_model.sv */
// Drive-side model: follows seeks and measures head load and unload spans
`timescale 1ns/10ps
module fcpd_drive_model (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        head_load,
	input  wire logic        seek_req,
	input  wire logic [7:0]  seek_cylinder,
	input  wire logic        xfer_active,
	output logic      [7:0]  head_cyl,
	output logic      [15:0] load_cycles,
	output logic      [15:0] unload_cycles
);
	logic [15:0] span_reg;
	logic        load_q;
	logic        xfer_q;
	// ---------------------------------------------
	// Head position and timing
	// ---------------------------------------------
	// Span counts loaded-but-idle cycles; reused for both the settle and unload waits
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			head_cyl      <= 8'h00;
			load_cycles   <= 16'h0000;
			unload_cycles <= 16'h0000;
			span_reg      <= 16'h0000;
			load_q        <= 1'b0;
			xfer_q        <= 1'b0;
		end else begin
			load_q <= head_load;
			xfer_q <= xfer_active;
			if (seek_req)
				head_cyl <= seek_cylinder;
			span_reg <= (head_load && !xfer_active) ? span_reg + 16'h0001 : 16'h0000;
			if (xfer_active && !xfer_q)
				load_cycles <= span_reg;
			if (load_q && !head_load)
				unload_cycles <= span_reg;
		end
	end
endmodule : fcpd_drive_model

/* floppy_command_parameter_decode_tb.sv */
// Self-checking bench for the command parameter decoder
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module floppy_command_parameter_decode_tb;
	import fcpd_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'b010;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, q;
	logic        hreadyout, hresp, head_load, head_select, seek_req, mfm_mode;
	logic        xfer_active, write_active, fifo_enable_n;
	logic [7:0]  seek_cylinder, cur_sector, gap3_len, gap2_len, precomp_start_track, head_cyl;
	logic [15:0] sector_bytes, host_bytes, load_cycles, unload_cycles;
	logic [3:0]  fifo_threshold;
	int bad_count = 0;
	int check_count = 0;
	always #2 sys_clk = ~sys_clk;
	fcpd_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .head_load(head_load),
		.head_select(head_select), .seek_req(seek_req), .seek_cylinder(seek_cylinder),
		.mfm_mode(mfm_mode), .xfer_active(xfer_active), .write_active(write_active),
		.cur_sector(cur_sector), .sector_bytes(sector_bytes), .host_bytes(host_bytes),
		.gap3_len(gap3_len), .gap2_len(gap2_len), .fifo_enable_n(fifo_enable_n),
		.fifo_threshold(fifo_threshold), .precomp_start_track(precomp_start_track));
	fcpd_drive_model drive (.sys_clk(sys_clk), .reset_n(reset_n), .head_load(head_load),
		.seek_req(seek_req), .seek_cylinder(seek_cylinder), .xfer_active(xfer_active),
		.head_cyl(head_cyl), .load_cycles(load_cycles), .unload_cycles(unload_cycles));
	// ---------------------------------------------
	// Bus access
	// ---------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		repeat (2) @(posedge sys_clk);
	endtask : bus
	task automatic wait_load(input logic lvl);
		for (int n = 0; n < 3000 && head_load !== lvl; n++) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
	endtask : wait_load
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// ---------------------------------------------
	// Tests
	// ---------------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK(fifo_enable_n, 1'b1)
		`CHK({fifo_threshold, precomp_start_track}, 12'h000)
		bus(1'b0, 8'h40, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		`CHK({hreadyout, hresp}, 2'b10)
		$display("test reset_values done");
		// Lock clear: software reset restores defaults; lock set keeps values
		for (int l = 0; l < 2; l++) begin
			bus(1'b1, ADDR_CONFIG, {7'h00, l[0], 24'h33_0500});
			`CHK({fifo_enable_n, fifo_threshold, precomp_start_track}, 13'h0533)
			bus(1'b1, ADDR_CONTROL, 32'h0000_0001);
			`CHK({fifo_enable_n, fifo_threshold, precomp_start_track}, l ? 13'h0533 : 13'h1000)
		end
		$display("test lock done");
		bus(1'b1, ADDR_TIMING, 32'h102A_0203);
		bus(1'b1, ADDR_CONFIG, 32'h0000_0000);
		`CHK(gap3_len, 8'h2A)
		`CHK(gap2_len, 8'h1B)
		bus(1'b1, ADDR_CONFIG, 32'h0400_0000);
		`CHK(gap2_len, 8'h10)
		bus(1'b0, ADDR_CONFIG, 32'h0000_0000);
		`CHK(q, 32'h0400_0000)
		bus(1'b0, ADDR_TIMING, 32'h0000_0000);
		`CHK(q, 32'h102A_0203)
		$display("test gaps done");
		// Every size code, both densities and heads, no implied seek; host keeps legal combos
		bus(1'b1, ADDR_CONFIG, 32'h0000_0000);
		bus(1'b1, ADDR_SECTOR, 32'h0000_0040);
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, ADDR_COMMAND, {1'b1, 2'b00, k[0], k[1], 24'h00_0000, k[2:0]});
			`CHK(sector_bytes, 16'h0080 << k)
			`CHK(host_bytes, (k == 0) ? 16'h0040 : (16'h0080 << k))
			`CHK(mfm_mode, k[0])
			`CHK(head_select, k[1])
			`CHK({seek_req, head_load}, 2'b01)
			bus(1'b1, ADDR_CONTROL, 32'h0000_0001);
		end
		$display("test size_codes done");
		// Implied seek, head settle, multi-track run across both heads, unload
		bus(1'b1, ADDR_CONFIG, 32'h0200_0000);
		bus(1'b1, ADDR_TRACK, 32'h0002_0121);
		bus(1'b1, ADDR_COMMAND, 32'hF000_0002);
		`CHK({seek_req, head_load, seek_cylinder}, 10'h221)
		bus(1'b1, ADDR_CONTROL, 32'h0000_0004);
		`CHK(head_cyl, 8'h21)
		for (int n = 0; n < 3000 && xfer_active !== 1'b1; n++) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
		`CHK(load_cycles >= 16'h01F4 && load_cycles <= 16'h03F0, 1'b1)
		`CHK({write_active, head_select, cur_sector}, 10'h201)
		bus(1'b1, ADDR_CONTROL, 32'h0000_0002);
		`CHK({xfer_active, head_select, cur_sector}, 10'h202)
		bus(1'b1, ADDR_CONTROL, 32'h0000_0002);
		`CHK({xfer_active, head_select, cur_sector}, 10'h301)
		bus(1'b1, ADDR_CONTROL, 32'h0000_0002);
		bus(1'b1, ADDR_CONTROL, 32'h0000_0002);
		`CHK({xfer_active, head_load}, 2'b01)
		wait_load(1'b0);
		`CHK(unload_cycles >= 16'h00FA && unload_cycles <= 16'h02F8, 1'b1)
		$display("test transfer done");
		summarize();
	end
	// Run should finish within about 1.5k cycles; this bound cuts a hang short
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		summarize();
	end
endmodule : floppy_command_parameter_decode_tb
